// File: pkg/palette_ctrl_pkg.sv
package palette_ctrl_pkg;
	localparam logic [7:0] IDX_GEN_CTRL   = 8'h1D;
	localparam logic [7:0] IDX_MISC_CTRL  = 8'h1E;
	localparam logic [7:0] IDX_CLK_SEL    = 8'h1A;
	localparam logic [7:0] IDX_SOFT_RESET = 8'hFF;
	localparam logic [7:0] GEN_CTRL_RST   = 8'h00;
	localparam logic [7:0] MISC_CTRL_RST  = 8'h00;
	localparam logic [7:0] CLK_SEL_RST    = 8'h00;
	localparam logic [7:0] RDATA_RST      = 8'h00;
	localparam logic [7:0] GEN_CTRL_MASK  = 8'h7B;
	localparam logic [7:0] MISC_CTRL_MASK = 8'h3D;
	localparam logic [2:0] CLK_SEL_OFF    = 3'h6;
	localparam int         BIT_OVERSCAN   = 6;
	localparam int         BIT_SOG        = 5;
	localparam int         BIT_PEDESTAL   = 4;
	localparam int         BIT_BYTE_ORDER = 3;
	localparam int         BIT_VSYNC_INV  = 1;
	localparam int         BIT_HSYNC_INV  = 0;
	localparam int         BIT_PSEL_POL   = 5;
	localparam int         BIT_PSEL_SW    = 4;
	localparam int         BIT_DAC_WIDTH  = 3;
	localparam int         BIT_WIDTH_OVR  = 2;
	localparam int         BIT_DAC_PD     = 0;
endpackage

// File: core/sync_2ff.sv
`timescale 1ns/1ns
module sync_2ff (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Data
	input  wire logic din,
	output logic      dout
);
	logic meta_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule // sync_2ff

// File: core/palette_general_misc_control.sv
`timescale 1ns/1ns
module palette_general_misc_control (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	// Indexed register port
	input  wire logic [7:0]                  reg_index,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [7:0]                  reg_wdata,
	output logic      [7:0]                  reg_rdata,
	// Pins
	input  wire logic                        width_terminal,
	input  wire logic                        port_select_in,
	input  wire logic                        color_key_direct,
	input  wire logic                        horiz_sync_in,
	input  wire logic                        vert_sync_in,
	// Control outputs
	output logic                             overscan_border_enable,
	output logic                             sync_on_green_enable,
	output logic                             pedestal_select,
	output logic                             pixel_bus_byte_order,
	output logic                             horiz_sync_output,
	output logic                             vert_sync_output,
	output logic                             port_select_polarity,
	output logic                             port_select_switch_enable,
	output logic                             direct_color_select,
	output logic                             dac_width_8bit,
	output logic                             dac_power_down,
	output logic                             dot_clock_enable
);
	import palette_ctrl_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic width_s;
	logic psel_s;
	logic hsync_s;
	logic vsync_s;
	sync_2ff u_sync_width (.clock(clock), .rst_n(rst_n), .din(width_terminal), .dout(width_s));
	sync_2ff u_sync_psel  (.clock(clock), .rst_n(rst_n), .din(port_select_in), .dout(psel_s));
	sync_2ff u_sync_hs    (.clock(clock), .rst_n(rst_n), .din(horiz_sync_in),  .dout(hsync_s));
	sync_2ff u_sync_vs    (.clock(clock), .rst_n(rst_n), .din(vert_sync_in),   .dout(vsync_s));

	// ****************************************
	// Register decode
	// ****************************************
	logic [7:0] gen_ctrl_ff;
	logic [7:0] misc_ctrl_ff;
	logic [7:0] clk_sel_ff;
	logic [7:0] nxt_gen_ctrl;
	logic [7:0] nxt_misc_ctrl;
	logic [7:0] nxt_clk_sel;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;

	wire wr_gen   = reg_wr && (reg_index == IDX_GEN_CTRL);
	wire wr_misc  = reg_wr && (reg_index == IDX_MISC_CTRL);
	wire wr_clk   = reg_wr && (reg_index == IDX_CLK_SEL);
	wire wr_soft  = reg_wr && (reg_index == IDX_SOFT_RESET);

	// Soft reset wins over any other write
	assign nxt_gen_ctrl  = wr_soft ? GEN_CTRL_RST :
	                       wr_gen  ? (reg_wdata & GEN_CTRL_MASK) : gen_ctrl_ff;
	assign nxt_misc_ctrl = wr_soft ? MISC_CTRL_RST :
	                       wr_misc ? (reg_wdata & MISC_CTRL_MASK) : misc_ctrl_ff;
	assign nxt_clk_sel   = wr_soft ? CLK_SEL_RST : wr_clk ? reg_wdata : clk_sel_ff;

	assign nxt_rdata = !reg_rd ? rdata_ff :
	                   (reg_index == IDX_GEN_CTRL)  ? gen_ctrl_ff :
	                   (reg_index == IDX_MISC_CTRL) ? misc_ctrl_ff :
	                   (reg_index == IDX_CLK_SEL)   ? clk_sel_ff : 8'h00;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gen_ctrl_ff  <= GEN_CTRL_RST;
			misc_ctrl_ff <= MISC_CTRL_RST;
			clk_sel_ff   <= CLK_SEL_RST;
			rdata_ff     <= RDATA_RST;
		end else begin
			gen_ctrl_ff  <= nxt_gen_ctrl;
			misc_ctrl_ff <= nxt_misc_ctrl;
			clk_sel_ff   <= nxt_clk_sel;
			rdata_ff     <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;

	// ****************************************
	// Control outputs
	// ****************************************
	logic hs_out_ff;
	logic vs_out_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hs_out_ff <= 1'b0;
			vs_out_ff <= 1'b0;
		end else begin
			hs_out_ff <= hsync_s ^ gen_ctrl_ff[BIT_HSYNC_INV];
			vs_out_ff <= vsync_s ^ gen_ctrl_ff[BIT_VSYNC_INV];
		end
	end
	assign horiz_sync_output         = hs_out_ff;
	assign vert_sync_output          = vs_out_ff;
	assign overscan_border_enable    = gen_ctrl_ff[BIT_OVERSCAN];
	assign sync_on_green_enable      = gen_ctrl_ff[BIT_SOG];
	assign pedestal_select           = gen_ctrl_ff[BIT_PEDESTAL];
	assign pixel_bus_byte_order      = gen_ctrl_ff[BIT_BYTE_ORDER];
	assign port_select_polarity      = misc_ctrl_ff[BIT_PSEL_POL];
	assign port_select_switch_enable = misc_ctrl_ff[BIT_PSEL_SW];
	// Effective port select level; direct colour needs color keying agreeing
	wire psel_eff = psel_s ^ misc_ctrl_ff[BIT_PSEL_POL];
	assign direct_color_select = misc_ctrl_ff[BIT_PSEL_SW] && psel_eff && color_key_direct;
	assign dac_width_8bit = misc_ctrl_ff[BIT_WIDTH_OVR] ? misc_ctrl_ff[BIT_DAC_WIDTH] : width_s;
	assign dac_power_down   = misc_ctrl_ff[BIT_DAC_PD];
	assign dot_clock_enable = (clk_sel_ff[2:0] != CLK_SEL_OFF);

	// ****************************************
	// Assertions
	// ****************************************
	property p_gen_write;
		@(posedge clock) disable iff (!rst_n)
		wr_gen && !wr_soft |=> gen_ctrl_ff == ($past(reg_wdata) & GEN_CTRL_MASK);
	endproperty
	a_gen_write: assert property (p_gen_write) else $error("general control write lost");

	property p_misc_write;
		@(posedge clock) disable iff (!rst_n)
		wr_misc |=> misc_ctrl_ff == ($past(reg_wdata) & MISC_CTRL_MASK);
	endproperty
	a_misc_write: assert property (p_misc_write) else $error("misc control write lost");

	sequence s_soft_reset;
		reg_wr && reg_index == IDX_SOFT_RESET;
	endsequence
	property p_soft_reset;
		@(posedge clock) disable iff (!rst_n)
		s_soft_reset |=> gen_ctrl_ff == 8'h00 && misc_ctrl_ff == 8'h00 && dot_clock_enable;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");

	property p_reserved;
		@(posedge clock) disable iff (!rst_n)
		(gen_ctrl_ff & ~GEN_CTRL_MASK) == 8'h00 && (misc_ctrl_ff & ~MISC_CTRL_MASK) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_hsync;
		@(posedge clock) disable iff (!rst_n)
		$stable(gen_ctrl_ff) |=> horiz_sync_output == ($past(hsync_s) ^ $past(gen_ctrl_ff[BIT_HSYNC_INV]));
	endproperty
	a_hsync: assert property (p_hsync) else $error("horizontal sync polarity wrong");

	property p_vsync;
		@(posedge clock) disable iff (!rst_n)
		1'b1 |=> vert_sync_output == ($past(vsync_s) ^ $past(gen_ctrl_ff[BIT_VSYNC_INV]));
	endproperty
	a_vsync: assert property (p_vsync) else $error("vertical sync polarity wrong");

	property p_width;
		@(posedge clock) disable iff (!rst_n)
		!misc_ctrl_ff[BIT_WIDTH_OVR] |-> dac_width_8bit == width_s;
	endproperty
	a_width: assert property (p_width) else $error("width terminal not followed");

	property p_width_ovr;
		@(posedge clock) disable iff (!rst_n)
		wr_misc && reg_wdata[BIT_WIDTH_OVR] |=> dac_width_8bit == $past(reg_wdata[BIT_DAC_WIDTH]);
	endproperty
	a_width_ovr: assert property (p_width_ovr) else $error("width override wrong");

	property p_dot_clock;
		@(posedge clock) disable iff (!rst_n)
		wr_clk && reg_wdata[2:0] == CLK_SEL_OFF |=> !dot_clock_enable;
	endproperty
	a_dot_clock: assert property (p_dot_clock) else $error("dot clock not stopped");

	property p_power_down;
		@(posedge clock) disable iff (!rst_n)
		wr_misc |=> dac_power_down == $past(reg_wdata[BIT_DAC_PD]);
	endproperty
	a_power_down: assert property (p_power_down) else $error("power down not applied");

	property p_psel;
		@(posedge clock) disable iff (!rst_n)
		!port_select_switch_enable |-> !direct_color_select;
	endproperty
	a_psel: assert property (p_psel) else $error("switching while disabled");

	property p_gen_hold;
		@(posedge clock) disable iff (!rst_n)
		!wr_gen && !wr_soft |=> $stable(gen_ctrl_ff);
	endproperty
	a_gen_hold: assert property (p_gen_hold) else $error("general control changed without write");

	property p_misc_hold;
		@(posedge clock) disable iff (!rst_n)
		!wr_misc && !wr_soft |=> $stable(misc_ctrl_ff);
	endproperty
	a_misc_hold: assert property (p_misc_hold) else $error("misc control changed without write");

	property p_clk_hold;
		@(posedge clock) disable iff (!rst_n)
		!wr_clk && !wr_soft |=> $stable(clk_sel_ff);
	endproperty
	a_clk_hold: assert property (p_clk_hold) else $error("clock select changed without write");

	property p_soft_clk;
		@(posedge clock) disable iff (!rst_n)
		s_soft_reset |=> clk_sel_ff == CLK_SEL_RST;
	endproperty
	a_soft_clk: assert property (p_soft_clk) else $error("soft reset left clock select");

	property p_read_gen;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_index == IDX_GEN_CTRL |=> reg_rdata == $past(gen_ctrl_ff);
	endproperty
	a_read_gen: assert property (p_read_gen) else $error("general control read wrong");

	property p_read_misc;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_index == IDX_MISC_CTRL |=> reg_rdata == $past(misc_ctrl_ff);
	endproperty
	a_read_misc: assert property (p_read_misc) else $error("misc control read wrong");

	property p_read_clk;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_index == IDX_CLK_SEL |=> reg_rdata == $past(clk_sel_ff);
	endproperty
	a_read_clk: assert property (p_read_clk) else $error("clock select read wrong");

	property p_read_unmapped;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_index != IDX_GEN_CTRL && reg_index != IDX_MISC_CTRL && reg_index != IDX_CLK_SEL
		|=> reg_rdata == 8'h00;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	property p_rdata_hold;
		@(posedge clock) disable iff (!rst_n)
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

	property p_overscan;
		@(posedge clock) disable iff (!rst_n)
		wr_gen |=> overscan_border_enable == $past(reg_wdata[BIT_OVERSCAN]);
	endproperty
	a_overscan: assert property (p_overscan) else $error("overscan enable wrong");

	property p_sog;
		@(posedge clock) disable iff (!rst_n)
		wr_gen |=> sync_on_green_enable == $past(reg_wdata[BIT_SOG]);
	endproperty
	a_sog: assert property (p_sog) else $error("sync on green wrong");

	property p_pedestal;
		@(posedge clock) disable iff (!rst_n)
		wr_gen |=> pedestal_select == $past(reg_wdata[BIT_PEDESTAL]);
	endproperty
	a_pedestal: assert property (p_pedestal) else $error("pedestal select wrong");

	property p_byte_order;
		@(posedge clock) disable iff (!rst_n)
		wr_gen |=> pixel_bus_byte_order == $past(reg_wdata[BIT_BYTE_ORDER]);
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("byte order wrong");

	property p_psel_pol;
		@(posedge clock) disable iff (!rst_n)
		wr_misc |=> port_select_polarity == $past(reg_wdata[BIT_PSEL_POL]);
	endproperty
	a_psel_pol: assert property (p_psel_pol) else $error("port select polarity wrong");

	property p_psel_sw;
		@(posedge clock) disable iff (!rst_n)
		wr_misc |=> port_select_switch_enable == $past(reg_wdata[BIT_PSEL_SW]);
	endproperty
	a_psel_sw: assert property (p_psel_sw) else $error("port select switching wrong");

	property p_direct_color;
		@(posedge clock) disable iff (!rst_n)
		port_select_switch_enable && color_key_direct |-> direct_color_select == (psel_s ^ port_select_polarity);
	endproperty
	a_direct_color: assert property (p_direct_color) else $error("direct colour choice wrong");

	property p_key_block;
		@(posedge clock) disable iff (!rst_n)
		!color_key_direct |-> !direct_color_select;
	endproperty
	a_key_block: assert property (p_key_block) else $error("direct colour without colour key");

	property p_dot_clock_on;
		@(posedge clock) disable iff (!rst_n)
		wr_clk && reg_wdata[2:0] != CLK_SEL_OFF |=> dot_clock_enable;
	endproperty
	a_dot_clock_on: assert property (p_dot_clock_on) else $error("dot clock stopped wrongly");

	property p_width_fixed;
		@(posedge clock) disable iff (!rst_n)
		misc_ctrl_ff[BIT_WIDTH_OVR] |-> dac_width_8bit == misc_ctrl_ff[BIT_DAC_WIDTH];
	endproperty
	a_width_fixed: assert property (p_width_fixed) else $error("override width not used");

	sequence s_read_gen;
		reg_rd && !reg_wr && reg_index == IDX_GEN_CTRL;
	endsequence
	property p_soft_readback;
		@(posedge clock) disable iff (!rst_n)
		s_soft_reset ##1 !reg_wr ##1 s_read_gen |=> reg_rdata == GEN_CTRL_RST;
	endproperty
	a_soft_readback: assert property (p_soft_readback) else $error("soft reset readback wrong");
endmodule // palette_general_misc_control

// File: verification/host_model.sv
`timescale 1ns/1ns
// ****
// Host side of the indexed register port
// ****
module host_model (
	// Clock
	input  wire logic       clock,
	// Register port
	output logic      [7:0] reg_index,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_index = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 8'h00;
	end
	// One-cycle write strobe; data is scrambled once released
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge clock);
		reg_index <= idx;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(negedge clock);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// One-cycle read strobe; data taken after the answering edge
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		@(negedge clock);
		reg_index <= idx;
		reg_rd    <= 1'b1;
		@(negedge clock);
		reg_rd <= 1'b0;
		d = reg_rdata;
	endtask
endmodule // host_model

// File: verification/tb_palette_general_misc_control.sv
`timescale 1ns/1ns
// ****
// Register bank bench
// ****
module tb_palette_general_misc_control;
	import palette_ctrl_pkg::*;
	logic       clock, rst_n, reg_wr, reg_rd, width_terminal, port_select_in;
	logic       color_key_direct, horiz_sync_in, vert_sync_in;
	logic [7:0] reg_index, reg_wdata, reg_rdata, rd_val;
	logic       overscan_border_enable, sync_on_green_enable, pedestal_select, pixel_bus_byte_order;
	logic       horiz_sync_output, vert_sync_output, port_select_polarity, port_select_switch_enable;
	logic       direct_color_select, dac_width_8bit, dac_power_down, dot_clock_enable;
	int         bad_count, checked, cycles;
	wire logic [7:0] gen_view = {1'b0, overscan_border_enable, sync_on_green_enable, pedestal_select,
		pixel_bus_byte_order, 1'b0, vert_sync_output, horiz_sync_output};
	wire logic [7:0] misc_view = {2'b00, port_select_polarity, port_select_switch_enable, dac_width_8bit,
		direct_color_select, dot_clock_enable, dac_power_down};
	palette_general_misc_control palette_general_misc_control_inst (.clock, .rst_n, .reg_index, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .width_terminal, .port_select_in, .color_key_direct, .horiz_sync_in,
		.vert_sync_in, .overscan_border_enable, .sync_on_green_enable, .pedestal_select, .pixel_bus_byte_order,
		.horiz_sync_output, .vert_sync_output, .port_select_polarity, .port_select_switch_enable,
		.direct_color_select, .dac_width_8bit, .dac_power_down, .dot_clock_enable);
	host_model host_model_inst (.clock, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		host_model_inst.rd(idx, rd_val);
		chk(rd_val, exp);
	endtask
	task automatic waitn(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		width_terminal = 1'b0;
		port_select_in = 1'b0;
		color_key_direct = 1'b1;
		horiz_sync_in = 1'b0;
		vert_sync_in = 1'b0;
		waitn(2);
		rst_n = 1'b1;
		rchk(IDX_GEN_CTRL, 8'h00);
		rchk(IDX_MISC_CTRL, 8'h00);
		chk(gen_view, 8'h00);
		chk(misc_view, 8'h02);
		horiz_sync_in = 1'b1;
		vert_sync_in = 1'b1;
		waitn(4);
		chk(gen_view, 8'h03);
		host_model_inst.wr(IDX_GEN_CTRL, 8'hFF);
		waitn(1);
		chk(gen_view, 8'h78);
		rchk(IDX_GEN_CTRL, 8'h7B);
		host_model_inst.wr(8'h1F, 8'hFF);
		rchk(8'h1F, 8'h00);
		rchk(IDX_GEN_CTRL, 8'h7B);
		port_select_in = 1'b1;
		width_terminal = 1'b1;
		host_model_inst.wr(IDX_MISC_CTRL, 8'hFF);
		waitn(2);
		chk(misc_view, 8'h3B);
		rchk(IDX_MISC_CTRL, 8'h3D);
		port_select_in = 1'b0;
		waitn(3);
		chk(misc_view, 8'h3F);
		host_model_inst.wr(IDX_MISC_CTRL, 8'h24);
		chk(misc_view, 8'h22);
		host_model_inst.wr(IDX_MISC_CTRL, 8'h10);
		chk(misc_view, 8'h1A);
		port_select_in = 1'b1;
		waitn(3);
		chk(misc_view, 8'h1E);
		color_key_direct = 1'b0;
		waitn(1);
		chk(misc_view, 8'h1A);
		host_model_inst.wr(IDX_CLK_SEL, 8'h06);
		chk(misc_view, 8'h18);
		host_model_inst.wr(IDX_CLK_SEL, 8'h07);
		chk(misc_view, 8'h1A);
		host_model_inst.wr(IDX_CLK_SEL, 8'h06);
		rchk(IDX_CLK_SEL, 8'h06);
		host_model_inst.wr(IDX_SOFT_RESET, 8'h5A);
		rchk(IDX_GEN_CTRL, 8'h00);
		rchk(IDX_MISC_CTRL, 8'h00);
		chk(misc_view, 8'h0A);
		host_model_inst.wr(IDX_GEN_CTRL, 8'h7B);
		rst_n = 1'b0;
		#1;
		chk(gen_view, 8'h00);
		waitn(2);
		rst_n = 1'b1;
		rchk(IDX_GEN_CTRL, 8'h00);
		end_of_test();
	end
endmodule // tb_palette_general_misc_control
